// [rtl/pio_pkg.sv]
// shared constants and types for the port instruction unit
package pio_pkg;
  localparam int         PIN_W       = 13;
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_ACC     = 8'h04;
  localparam logic [7:0] OFS_INDEX   = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_PORTS   = 8'h10;
  localparam logic [7:0] OFS_PINS    = 8'h14;
  localparam logic [7:0] OFS_CFG     = 8'h18;
  localparam int         ST_SKIP     = 0;
  localparam int         ST_BUSY     = 1;
  localparam int         ST_RANGE    = 2;
  localparam logic [3:0] D_MAX_INDEX = 4'h4;
  localparam logic [3:0] ACC_RST     = 4'h0;
  localparam logic [3:0] INDEX_RST   = 4'h0;
  localparam logic [3:0] CFG_RST     = 4'h0;
  localparam logic [4:0] D_RST       = 5'h00;
  localparam logic [4:0] D_ALL_ONES  = 5'h1F;

  typedef enum logic [4:0] {
    OP_NOP     = 5'b00000,
    OP_IN_N0   = 5'b00001,
    OP_OUT_N0  = 5'b00010,
    OP_IN_N1   = 5'b00011,
    OP_OUT_N1  = 5'b00100,
    OP_IN_P0   = 5'b00101,
    OP_OUT_P0  = 5'b00110,
    OP_IN_P1   = 5'b00111,
    OP_OUT_P1  = 5'b01000,
    OP_D_ALL   = 5'b01001,
    OP_D_CLR   = 5'b01010,
    OP_D_SET   = 5'b01011,
    OP_D_TEST  = 5'b01100,
    OP_C_CLR   = 5'b01101,
    OP_C_SET   = 5'b01110,
    OP_WR_DRV0 = 5'b01111,
    OP_WR_DRV1 = 5'b10000,
    OP_RD_PU0  = 5'b10001,
    OP_WR_PU0  = 5'b10010,
    OP_RD_PU1  = 5'b10011,
    OP_WR_PU1  = 5'b10100,
    OP_RD_PU2  = 5'b10101,
    OP_WR_PU2  = 5'b10110,
    OP_IN_K    = 5'b10111
  } pio_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } pio_state_t;

  typedef struct packed {
    logic       k_input;
    logic [1:0] second_pair_port;
    logic [1:0] first_pair_port;
    logic [3:0] second_nibble_port;
    logic [3:0] first_nibble_port;
  } pio_pins_t;

  typedef struct packed {
    logic       c_port;
    logic [4:0] d_port;
    logic [1:0] second_pair_port;
    logic [1:0] first_pair_port;
    logic [3:0] second_nibble_port;
    logic [3:0] first_nibble_port;
  } pio_outs_t;

  typedef struct packed {
    logic [3:0] pullup_select_third;
    logic [3:0] pullup_select_second;
    logic [3:0] pullup_select_first;
    logic [3:0] drive_type_reg_second;
    logic [3:0] drive_type_reg_first;
  } pio_cfg_t;
endpackage

// [rtl/pio_port_unit.sv]
// port input/output instruction unit with apb command access
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module pio_port_unit
  import pio_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire pio_pins_t   pins_in,
  output pio_outs_t        pins_out,
  output pio_cfg_t         cfg_out
);

  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] sync2_reg;
  logic [PIN_W-1:0] sync3_reg;
  pio_pins_t        pins_reg;
  logic [31:0]      prdata_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  logic [31:0]      rdata_next;
  logic             hit_next;
  pio_state_t       state_reg;
  pio_op_t          op_reg;
  logic [3:0]       acc_reg;
  logic [3:0]       index_reg;
  logic             skip_reg;
  logic             range_reg;
  pio_outs_t        outs_reg;
  pio_cfg_t         cfg_reg;
  logic             access;
  logic             done;
  logic             ex;
  logic             in_range;
  logic             d_sel;

  assign prdata   = prdata_reg;
  assign pready   = pready_reg;
  assign pslverr  = pslverr_reg;
  assign pins_out = outs_reg;
  assign cfg_out  = cfg_reg;

  assign access   = psel & penable;
  assign done     = access & pready_reg;
  assign ex       = (state_reg == ST_EXEC) & ~skip_reg;
  assign in_range = (index_reg <= D_MAX_INDEX);
  assign d_sel    = in_range ? outs_reg.d_port[index_reg[2:0]] : 1'b1;

  // pin synchronisers, a change counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  for (genvar i = 0; i < PIN_W; i++) begin : g_pin
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pins_reg[i] <= 1'b0;
      end else if (sync2_reg[i] == sync3_reg[i]) begin
        pins_reg[i] <= sync3_reg[i];
      end
    end
  end

  // apb read decode
  always_comb begin
    rdata_next = '0;
    hit_next   = 1'b1;
    case (paddr)
      OFS_CMD:    rdata_next[4:0] = op_reg;
      OFS_ACC:    rdata_next[3:0] = acc_reg;
      OFS_INDEX:  rdata_next[3:0] = index_reg;
      OFS_STATUS: rdata_next[2:0] = {range_reg, state_reg == ST_EXEC, skip_reg};
      OFS_PORTS:  rdata_next[$bits(pio_outs_t)-1:0] = outs_reg;
      OFS_PINS:   rdata_next[PIN_W-1:0] = pins_reg;
      OFS_CFG:    rdata_next[$bits(pio_cfg_t)-1:0] = cfg_reg;
      default:    hit_next = 1'b0;
    endcase
  end

  // one wait state, then the answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= access & ~pready_reg;
      pslverr_reg <= access & ~pready_reg & ~hit_next;
      prdata_reg  <= (access & ~pready_reg & ~pwrite) ? rdata_next : '0;
    end
  end

  // command capture and execution sequence
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_NOP;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (done & pwrite & (paddr == OFS_CMD)) begin
            op_reg    <= pio_op_t'(pwdata[4:0]);
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // accumulator
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg <= ACC_RST;
    end else if (ex) begin
      case (op_reg)
        OP_IN_N0:  acc_reg <= pins_reg.first_nibble_port;
        OP_IN_N1:  acc_reg <= pins_reg.second_nibble_port;
        OP_IN_P0:  acc_reg <= {2'b00, pins_reg.first_pair_port};
        OP_IN_P1:  acc_reg <= {2'b00, pins_reg.second_pair_port};
        OP_IN_K:   acc_reg <= {3'b000, pins_reg.k_input};
        OP_RD_PU0: acc_reg <= cfg_reg.pullup_select_first;
        OP_RD_PU1: acc_reg <= cfg_reg.pullup_select_second;
        OP_RD_PU2: acc_reg <= cfg_reg.pullup_select_third;
        default:   acc_reg <= acc_reg;
      endcase
    end else if (done & pwrite & (paddr == OFS_ACC)) begin
      acc_reg <= pwdata[3:0];
    end
  end

  // index register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      index_reg <= INDEX_RST;
    end else if (done & pwrite & (paddr == OFS_INDEX)) begin
      index_reg <= pwdata[3:0];
    end
  end

  // port output latches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outs_reg <= '{c_port: 1'b0, d_port: D_RST, default: '0};
    end else if (ex) begin
      case (op_reg)
        OP_OUT_N0: outs_reg.first_nibble_port  <= acc_reg;
        OP_OUT_N1: outs_reg.second_nibble_port <= acc_reg;
        OP_OUT_P0: outs_reg.first_pair_port    <= acc_reg[1:0];
        OP_OUT_P1: outs_reg.second_pair_port   <= acc_reg[1:0];
        OP_D_ALL:  outs_reg.d_port <= D_ALL_ONES;
        OP_D_CLR: begin
          if (in_range) begin
            outs_reg.d_port[index_reg[2:0]] <= 1'b0;
          end
        end
        OP_D_SET: begin
          if (in_range) begin
            outs_reg.d_port[index_reg[2:0]] <= 1'b1;
          end
        end
        OP_C_CLR:  outs_reg.c_port <= 1'b0;
        OP_C_SET:  outs_reg.c_port <= 1'b1;
        default:   outs_reg <= outs_reg;
      endcase
    end
  end

  // drive type and pull-up registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= '{default: CFG_RST};
    end else if (ex) begin
      case (op_reg)
        OP_WR_DRV0: cfg_reg.drive_type_reg_first  <= acc_reg;
        OP_WR_DRV1: cfg_reg.drive_type_reg_second <= acc_reg;
        OP_WR_PU0:  cfg_reg.pullup_select_first   <= acc_reg;
        OP_WR_PU1:  cfg_reg.pullup_select_second  <= acc_reg;
        OP_WR_PU2:  cfg_reg.pullup_select_third   <= acc_reg;
        default:    cfg_reg <= cfg_reg;
      endcase
    end
  end

  // skip flag, consumed by the next command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      skip_reg <= 1'b0;
    end else if (state_reg == ST_EXEC) begin
      if (skip_reg) begin
        skip_reg <= 1'b0;
      end else if (op_reg == OP_D_TEST) begin
        skip_reg <= ~d_sel;
      end
    end
  end

  // index range error, sticky; set wins over the write-one clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      range_reg <= 1'b0;
    end else if (ex & ~in_range & ((op_reg == OP_D_CLR) | (op_reg == OP_D_SET) |
                                   (op_reg == OP_D_TEST))) begin
      range_reg <= 1'b1;
    end else if (done & pwrite & (paddr == OFS_STATUS) & pwdata[ST_RANGE]) begin
      range_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_in_n0;
    ex && op_reg == OP_IN_N0 |=> acc_reg == $past(pins_reg.first_nibble_port);
  endproperty
  a_in_n0: assert property (p_in_n0) else $error("nibble port 1 read wrong");
  property p_out_n0;
    ex && op_reg == OP_OUT_N0 |=> pins_out.first_nibble_port == $past(acc_reg);
  endproperty
  a_out_n0: assert property (p_out_n0) else $error("nibble port 1 write wrong");
  property p_in_n1;
    ex && op_reg == OP_IN_N1 |=> acc_reg == $past(pins_reg.second_nibble_port);
  endproperty
  a_in_n1: assert property (p_in_n1) else $error("nibble port 2 read wrong");
  property p_out_n1;
    ex && op_reg == OP_OUT_N1 |=> pins_out.second_nibble_port == $past(acc_reg);
  endproperty
  a_out_n1: assert property (p_out_n1) else $error("nibble port 2 write wrong");
  property p_in_p0;
    ex && op_reg == OP_IN_P0 |=> acc_reg[3:2] == 2'b00 &&
      acc_reg[1:0] == $past(pins_reg.first_pair_port);
  endproperty
  a_in_p0: assert property (p_in_p0) else $error("pair port 1 read wrong");
  property p_out_p0;
    ex && op_reg == OP_OUT_P0 |=> pins_out.first_pair_port == $past(acc_reg[1:0]);
  endproperty
  a_out_p0: assert property (p_out_p0) else $error("pair port 1 write wrong");
  property p_in_p1;
    ex && op_reg == OP_IN_P1 |=> acc_reg[3:2] == 2'b00 &&
      acc_reg[1:0] == $past(pins_reg.second_pair_port);
  endproperty
  a_in_p1: assert property (p_in_p1) else $error("pair port 2 read wrong");
  property p_out_p1;
    ex && op_reg == OP_OUT_P1 |=> pins_out.second_pair_port == $past(acc_reg[1:0]);
  endproperty
  a_out_p1: assert property (p_out_p1) else $error("pair port 2 write wrong");
  property p_d_clr;
    ex && op_reg == OP_D_CLR && in_range |=> !d_sel;
  endproperty
  a_d_clr: assert property (p_d_clr) else $error("d bit not cleared");
  property p_d_set;
    ex && (op_reg == OP_D_SET || op_reg == OP_D_ALL) && in_range |=> d_sel;
  endproperty
  a_d_set: assert property (p_d_set) else $error("d bit not set");
  property p_test;
    ex && op_reg == OP_D_TEST |=> skip_reg == !$past(d_sel);
  endproperty
  a_test: assert property (p_test) else $error("skip decision wrong");
  property p_c;
    ex && (op_reg == OP_C_SET || op_reg == OP_C_CLR) |=>
      pins_out.c_port == ($past(op_reg) == OP_C_SET);
  endproperty
  a_c: assert property (p_c) else $error("c port wrong");
  property p_drv0;
    ex && op_reg == OP_WR_DRV0 |=> cfg_out.drive_type_reg_first == $past(acc_reg);
  endproperty
  a_drv0: assert property (p_drv0) else $error("drive type 1 wrong");
  property p_drv1;
    ex && op_reg == OP_WR_DRV1 |=> cfg_out.drive_type_reg_second == $past(acc_reg);
  endproperty
  a_drv1: assert property (p_drv1) else $error("drive type 2 wrong");
  property p_rd_pu;
    ex && op_reg == OP_RD_PU2 |=> acc_reg == $past(cfg_reg.pullup_select_third);
  endproperty
  a_rd_pu: assert property (p_rd_pu) else $error("pull-up read wrong");
  property p_wr_pu;
    ex && op_reg == OP_WR_PU1 |=> cfg_out.pullup_select_second == $past(acc_reg);
  endproperty
  a_wr_pu: assert property (p_wr_pu) else $error("pull-up write wrong");
  property p_in_k;
    ex && op_reg == OP_IN_K |=> acc_reg == {3'b000, $past(pins_reg.k_input)};
  endproperty
  a_in_k: assert property (p_in_k) else $error("k input read wrong");
  property p_skip;
    skip_reg && state_reg == ST_EXEC |=> !skip_reg && $stable(outs_reg) &&
      $stable(cfg_reg) && $stable(acc_reg);
  endproperty
  a_skip: assert property (p_skip) else $error("skipped command had effect");

  c_skip: cover property (ex && op_reg == OP_D_TEST ##1 skip_reg ##[1:20] !skip_reg);
  c_err:  cover property (done && pslverr_reg);
  c_out:  cover property (ex && op_reg == OP_OUT_N0 ##1 pins_out.first_nibble_port != 4'h0);
endmodule

// [testbench/pio_pin_model.sv]
// external circuitry that sets the levels seen on the port pins
`timescale 1ns/1ps
module pio_pin_model
  import pio_pkg::*;
(
  input  wire pio_outs_t outs,
  input  wire pio_pins_t lvl,
  output pio_pins_t      pins
);
  // levels are held steady until the bench changes them
  assign pins = lvl;
endmodule

// [testbench/pio_port_unit_tb.sv]
// self-checking bench for the port instruction unit
`timescale 1ns/1ps
module pio_port_unit_tb;
  import pio_pkg::*;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  pio_pins_t   pins;
  pio_pins_t   lvl;
  pio_outs_t   pins_out;
  pio_cfg_t    cfg_out;
  pio_outs_t   mo;
  pio_cfg_t    mc;
  logic [3:0]  ma;
  logic [33:0] q[$];
  logic [33:0] e;
  int          n_fail;
  int          samples_checked;
  int          seed;

  pio_port_unit u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins_in(pins), .pins_out(pins_out),
    .cfg_out(cfg_out));
  pio_pin_model u_pins (.outs(pins_out), .lvl(lvl), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, s, x);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic er);
    q.push_back({1'b0, er, 32'h0});
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic er);
    q.push_back({1'b1, er, x});
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic ex(input pio_op_t op);
    wr(OFS_CMD, 32'(op), 1'b0);
  endtask

  task automatic wa(input logic [3:0] v);
    ma = v;
    wr(OFS_ACC, 32'(v), 1'b0);
  endtask

  task automatic po();
    rd(OFS_PORTS, 32'(mo), 1'b0);
    chk(32'(pins_out), 32'(mo));
    chk(32'(cfg_out), 32'(mc));
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic stop_test();
    $display("checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        e = q.pop_front();
        chk(32'(pslverr), 32'(e[32]));
        if (e[33]) begin
          chk(prdata, e[31:0]);
        end
      end
    end
  end

  initial begin
    #(100 * 20000);
    n_fail++;
    stop_test();
  end

  initial begin
    seed = 7;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    lvl = '0;
    mo = '0;
    mc = '0;
    ma = 4'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    po();
    rd(OFS_ACC, 32'h0, 1'b0);
    done("reset");
    for (int i = 0; i < 4; i++) begin
      lvl <= pio_pins_t'(13'($random(seed)));
      repeat (8) @(posedge clk);
      ex(OP_IN_N0); rd(OFS_ACC, 32'(lvl.first_nibble_port), 1'b0);
      ex(OP_IN_N1); rd(OFS_ACC, 32'(lvl.second_nibble_port), 1'b0);
      ex(OP_IN_P0); rd(OFS_ACC, 32'(lvl.first_pair_port), 1'b0);
      ex(OP_IN_P1); rd(OFS_ACC, 32'(lvl.second_pair_port), 1'b0);
      ex(OP_IN_K); rd(OFS_ACC, 32'(lvl.k_input), 1'b0);
      wa(4'($random(seed))); ex(OP_OUT_N0); mo.first_nibble_port = ma; po();
      wa(4'($random(seed))); ex(OP_OUT_N1); mo.second_nibble_port = ma; po();
      wa(4'($random(seed)) | 4'hC); ex(OP_OUT_P0); mo.first_pair_port = ma[1:0]; po();
      wa(4'($random(seed)) | 4'hC); ex(OP_OUT_P1); mo.second_pair_port = ma[1:0]; po();
    end
    done("ports");
    ex(OP_D_ALL); mo.d_port = D_ALL_ONES; po();
    for (int y = 0; y < 5; y++) begin
      wr(OFS_INDEX, 32'(y), 1'b0);
      ex(OP_D_CLR); mo.d_port[y] = 1'b0; po();
      if (y % 2 == 1) begin
        ex(OP_D_SET); mo.d_port[y] = 1'b1; po();
      end
    end
    wr(OFS_INDEX, 32'h4, 1'b0);
    ex(OP_D_TEST); ex(OP_C_SET); po();
    ex(OP_C_SET); mo.c_port = 1'b1; po();
    wr(OFS_INDEX, 32'h3, 1'b0);
    ex(OP_D_TEST); ex(OP_C_CLR); mo.c_port = 1'b0; po();
    done("d and c ports");
    wa(4'($random(seed))); ex(OP_WR_DRV0); mc.drive_type_reg_first = ma; po();
    wa(4'($random(seed))); ex(OP_WR_DRV1); mc.drive_type_reg_second = ma; po();
    wa(4'hA); ex(OP_WR_PU0); mc.pullup_select_first = ma; po();
    wa(4'h5); ex(OP_WR_PU1); mc.pullup_select_second = ma; po();
    wa(4'hC); ex(OP_WR_PU2); mc.pullup_select_third = ma; po();
    ex(OP_RD_PU0); rd(OFS_ACC, 32'hA, 1'b0);
    ex(OP_RD_PU1); rd(OFS_ACC, 32'h5, 1'b0);
    ex(OP_RD_PU2); rd(OFS_ACC, 32'hC, 1'b0);
    wr(OFS_INDEX, 32'h5, 1'b0);
    ex(OP_D_CLR); po();
    rd(OFS_STATUS, 32'h4, 1'b0);
    ex(OP_D_TEST); ex(OP_C_SET); mo.c_port = 1'b1; po();
    wr(OFS_STATUS, 32'h4, 1'b0);
    rd(OFS_STATUS, 32'h0, 1'b0);
    rd(OFS_CMD, 32'(OP_C_SET), 1'b0);
    rd(OFS_PINS, 32'(lvl), 1'b0);
    rd(OFS_CFG, 32'(mc), 1'b0);
    ex(OP_NOP); po();
    done("config");
    wr(8'h40, 32'hF, 1'b1);
    rd(8'h40, 32'h0, 1'b1);
    po();
    done("unmapped");
    stop_test();
  end
endmodule
